// ### pptb_top.sv
// Operation
// R1 - Enable bit runs or stops whole module; here only the time base stops, generator status and irqs keep running
// R2 - Idle halt bit stops time base idle
// R3 - Special event pending bit shows pending
// R4 - Special event enable gates its request
// R5 - Period update immediate or at rollover
// R6 - Polarity bit makes sync input active-low
// R7 - Sync output enable drives sync output
// R8 - External sync enable restarts time base
// R9 - Source code 000 selects sync pin
// R10 - Postscaler divides triggers by code plus one
// R11 - Period holds upper thirteen bits only
// R12 - Compare holds upper thirteen bits only
// R13 - Master duty is full sixteen bits
// R14 - Software keeps master duty in range
// R15 - Fault status set pending, cleared disabling
// R16 - Current-limit status set, cleared disabling
// R17 - Trigger status set, cleared disabling
// R18 - Fault enable gates requests, clears status
// R19 - Software clears local and controller flags
// R20 - Shared duty select picks master duty
// R21 - Own period select uses phase period
// R22 - Dead-time mode codes positive, negative, off
// R23 - Duty update immediate or time-base synced
// R24 - Counter counts, restarts after period
// R25 - Compare match makes postscaled special event
//
// The APB slave port and the address map were left to the implementer.
`timescale 1ns/10ps
`default_nettype none

module pptb_top (
  input  wire logic                  sys_clk_in,          // 10 MHz clock
  input  wire logic                  sys_rst_in,          // Sync reset
  input  wire logic                  psel_in,             // APB select
  input  wire logic                  penable_in,          // APB enable
  input  wire logic                  pwrite_in,           // APB write
  input  wire logic [7:0]            paddr_in,            // APB address
  input  wire logic [31:0]           pwdata_in,           // APB wdata
  output var  logic [31:0]           prdata_out,          // APB rdata
  output var  logic                  pready_out,          // APB ready
  output var  logic                  pslverr_out,         // APB error
  input  wire logic                  cpu_idle_in,         // CPU in idle
  input  wire logic                  sync_input_pin_in,   // Sync pin
  input  wire pptb_pkg::pptb_gen_evt_t [3:0] gen_evt_in,  // Gen events
  output var  logic                  sync_output_pin_out, // Sync out
  output var  logic                  special_evt_trig_out,// Trigger
  output var  logic                  special_evt_irq_out, // Irq request
  output var  logic [3:0]            gen_irq_out,         // Gen irqs
  output var  logic [15:0]           primary_counter_out, // Time base
  output var  logic [15:0]           master_duty_out,     // Master duty
  output var  logic [15:0]           active_period_out,   // Period
  output var  pptb_pkg::pptb_gen_cfg_t [3:0] gen_cfg_out  // Gen config
);

  // ----------------------------------------------------------------
  // APB decode
  // ----------------------------------------------------------------
  logic        pready_q;   // Ready, one wait state
  logic        acc_go;     // Access completes this edge
  logic        wr_go;      // Write takes effect this edge
  logic        sel_tbc;    // Address hits time base control
  logic        sel_per;    // Address hits period
  logic        sel_sec;    // Address hits compare
  logic        sel_mdc;    // Address hits master duty
  logic        sel_cnt;    // Address hits counter
  logic [3:0]  sel_gen;    // Address hits generator control
  logic        mapped;     // Any register hit
  logic [15:0] wd;         // Low half of write data

  assign acc_go  = psel_in && penable_in && pready_q;
  assign wr_go   = acc_go && pwrite_in;
  assign wd      = pwdata_in[15:0];
  assign sel_tbc = (paddr_in == pptb_pkg::OFS_TBC);
  assign sel_per = (paddr_in == pptb_pkg::OFS_PER);
  assign sel_sec = (paddr_in == pptb_pkg::OFS_SEC);
  assign sel_mdc = (paddr_in == pptb_pkg::OFS_MDC);
  assign sel_cnt = (paddr_in == pptb_pkg::OFS_CNT);
  assign mapped  = sel_tbc | sel_per | sel_sec | sel_mdc | sel_cnt
                 | (|sel_gen);

  // ----------------------------------------------------------------
  // Registers
  // ----------------------------------------------------------------
  logic [15:0] tbc_q;      // Time base control, pending bit apart
  logic        sep_q;      // Special event pending
  localparam int CMP_LSB_W = pptb_pkg::CMP_LSB; // Local alias
  logic [15:CMP_LSB_W] per_q; // Written period
  logic [15:CMP_LSB_W] act_q; // Active period
  logic [15:CMP_LSB_W] sec_q; // Special event compare
  logic [15:0] mdc_q;      // Master duty
  logic [15:0] cnt_q;      // Primary counter

  // Control fields pulled out of the time base control word
  logic       module_on;             // Module enabled
  logic       idle_halt_sel;         // Halt during idle
  logic       special_evt_irq_en;    // Special event irq enable
  logic       period_update_now;     // Immediate period update
  logic       sync_in_invert;        // Sync input active-low
  logic       sync_out_en;           // Sync output enable
  logic       ext_sync_en;           // External sync enable
  logic [2:0] sync_source_sel;       // Sync source
  logic [3:0] special_evt_postscale; // Postscale ratio code

  assign module_on             = tbc_q[pptb_pkg::TBC_ON];
  assign idle_halt_sel         = tbc_q[pptb_pkg::TBC_IDL];
  assign special_evt_irq_en    = tbc_q[pptb_pkg::TBC_SEE];
  assign period_update_now     = tbc_q[pptb_pkg::TBC_PUN];
  assign sync_in_invert        = tbc_q[pptb_pkg::TBC_SPOL];
  assign sync_out_en           = tbc_q[pptb_pkg::TBC_SOE];
  assign ext_sync_en           = tbc_q[pptb_pkg::TBC_SEN];
  assign sync_source_sel       = tbc_q[pptb_pkg::TBC_SRC +: 3];
  assign special_evt_postscale = tbc_q[pptb_pkg::TBC_PS +: 4];

  // Bits software may store in time base control
  localparam logic [15:0] TBC_WMASK = 16'hAFFF;

  // ----------------------------------------------------------------
  // Sync input synchroniser and edge detect
  // ----------------------------------------------------------------
  logic sync_m_q;   // First stage, read only by second
  logic sync_s_q;   // Second stage
  logic sync_d_q;   // Delayed copy for edge detect
  logic sync_lvl;   // Polarity-corrected level
  logic sync_lvl_d; // Polarity-corrected delayed level
  logic ext_rst;    // External restart of the time base

  // Pin is asynchronous, so two flops before any logic reads it
  always_ff @(posedge sys_clk_in) begin
    if (sys_rst_in) begin
      sync_m_q <= 1'b0;
      sync_s_q <= 1'b0;
      sync_d_q <= 1'b0;
    end else begin
      sync_m_q <= sync_input_pin_in;
      sync_s_q <= sync_m_q;
      sync_d_q <= sync_s_q;
    end
  end

  assign sync_lvl   = sync_s_q ^ sync_in_invert;  // R6
  assign sync_lvl_d = sync_d_q ^ sync_in_invert;  // R6
  // Reserved source codes select nothing, so they never restart
  assign ext_rst    = module_on && ext_sync_en                 // R8
                    && (sync_source_sel == pptb_pkg::SRC_PIN)   // R9
                    && sync_lvl && !sync_lvl_d;

  // ----------------------------------------------------------------
  // Primary time base
  // ----------------------------------------------------------------
  logic        run;      // Counter advances this cycle
  logic        roll;     // Counter wraps this cycle
  logic [15:0] act_full; // Active period, low bits zero
  logic [15:0] sec_full; // Compare value, low bits zero
  logic        sev_hit;  // Compare match
  logic        sev_trig; // Postscaled special event

  assign run      = module_on                                   // R1
                  && !(cpu_idle_in && idle_halt_sel);          // R2
  assign act_full = {act_q, {CMP_LSB_W{1'b0}}};
  assign sec_full = {sec_q, {CMP_LSB_W{1'b0}}};
  assign roll     = run && (cnt_q >= act_full);                // R24
  assign sev_hit  = run && (cnt_q == sec_full);                // R25

  // Counter clears when the module is off so it restarts clean
  always_ff @(posedge sys_clk_in) begin
    if (sys_rst_in || !module_on) begin
      cnt_q <= pptb_pkg::RST_WORD;                              // R1
    end else if (ext_rst || roll) begin
      cnt_q <= pptb_pkg::RST_WORD;                              // R8 R24
    end else if (run) begin
      cnt_q <= cnt_q + 16'h0001;                                // R24
    end
  end

  // Postscaler restarts whenever the module is off
  pptb_postscale u_post (
    .sys_clk_in (sys_clk_in),
    .sys_rst_in (sys_rst_in),
    .clear_in   (!module_on),
    .evt_in     (sev_hit),
    .ratio_in   (special_evt_postscale),
    .trig_out   (sev_trig)
  );

  // ----------------------------------------------------------------
  // Time base control, period, compare and master duty registers
  // ----------------------------------------------------------------
  logic sep_clr; // Software writes a zero to the pending bit

  assign sep_clr = wr_go && sel_tbc && !wd[pptb_pkg::TBC_SEP];

  // Software writes only; pending flag kept in its own flop
  always_ff @(posedge sys_clk_in) begin
    if (sys_rst_in) begin
      tbc_q <= pptb_pkg::RST_WORD;
    end else if (wr_go && sel_tbc) begin
      tbc_q <= wd & TBC_WMASK;                                  // R1 R2
    end
  end

  // A trigger in the clearing cycle wins over the clear
  always_ff @(posedge sys_clk_in) begin
    if (sys_rst_in) begin
      sep_q <= 1'b0;
    end else begin
      sep_q <= (sep_q && !sep_clr) || sev_trig;                 // R3 R25
    end
  end

  // Period: immediate copy, or held until the next wrap; copied every cycle while the module is off
  always_ff @(posedge sys_clk_in) begin
    if (sys_rst_in) begin
      per_q <= '0;
      act_q <= '0;
    end else begin
      if (wr_go && sel_per) begin
        per_q <= wd[15:CMP_LSB_W];                              // R11
      end
      if (wr_go && sel_per && period_update_now) begin
        act_q <= wd[15:CMP_LSB_W];                              // R5
      end else if (roll || !module_on) begin
        act_q <= per_q;                                         // R5
      end
    end
  end

  // Compare and master duty are plain storage
  always_ff @(posedge sys_clk_in) begin
    if (sys_rst_in) begin
      sec_q <= '0;
      mdc_q <= pptb_pkg::RST_WORD;
    end else begin
      if (wr_go && sel_sec) begin
        sec_q <= wd[15:CMP_LSB_W];                              // R12
      end
      if (wr_go && sel_mdc) begin
        mdc_q <= wd;                                            // R13
      end
    end
  end

  // ----------------------------------------------------------------
  // Per-generator control and interrupt status
  // ----------------------------------------------------------------
  logic [15:0] gen_rd [pptb_pkg::NUM_GEN]; // Read view per generator
  logic [2:0]  gstat_q [pptb_pkg::NUM_GEN]; // Fault, limit, trigger
  pptb_pkg::pptb_gen_cfg_t gcfg_q [pptb_pkg::NUM_GEN]; // Config
  logic [3:0]  girq;                       // Per-generator request

  genvar g;
  generate
    for (g = 0; g < pptb_pkg::NUM_GEN; g++) begin : g_gen
      logic       wr_me;  // Write to this generator
      logic [2:0] en_q;   // Current enables
      logic [2:0] en_d;   // Enables after this cycle
      logic [2:0] evt;    // Event pulses

      assign sel_gen[g] = (paddr_in == 8'(int'(pptb_pkg::OFS_GEN0)
                          + g * pptb_pkg::GEN_STEP));
      assign wr_me = wr_go && sel_gen[g];
      assign en_q  = {gcfg_q[g].fault_irq_en, gcfg_q[g].curlimit_irq_en,
                      gcfg_q[g].trig_irq_en};
      assign en_d  = wr_me ? wd[pptb_pkg::GC_TEN +: 3] : en_q;
      assign evt   = {gen_evt_in[g].fault, gen_evt_in[g].curlimit,
                      gen_evt_in[g].trig};
      assign girq[g] = |(gstat_q[g] & en_q);                    // R18

      // Status sets only while enabled; a zero enable clears it,
      // but an event in that same cycle still lands
      always_ff @(posedge sys_clk_in) begin
        if (sys_rst_in) begin
          gstat_q[g] <= 3'h0;
        end else begin
          gstat_q[g] <= (gstat_q[g] & en_d) | (evt & en_q);     // R15 R16 R17 R18
        end
      end

      // Reserved dead-time code is kept off the output stage
      always_ff @(posedge sys_clk_in) begin
        if (sys_rst_in) begin
          gcfg_q[g] <= '0;
        end else if (wr_me) begin
          gcfg_q[g].fault_irq_en        <= wd[pptb_pkg::GC_FEN];  // R18
          gcfg_q[g].curlimit_irq_en     <= wd[pptb_pkg::GC_CEN];
          gcfg_q[g].trig_irq_en         <= wd[pptb_pkg::GC_TEN];
          gcfg_q[g].own_period_sel      <= wd[pptb_pkg::GC_OPS];  // R21
          gcfg_q[g].shared_duty_sel     <= wd[pptb_pkg::GC_SDS];  // R20
          if (wd[pptb_pkg::GC_DT +: 2] != pptb_pkg::DT_RSVD) begin
            gcfg_q[g].deadtime_mode     <= wd[pptb_pkg::GC_DT +: 2]; // R22
          end
          gcfg_q[g].ext_counter_restart <= wd[pptb_pkg::GC_XR];
          gcfg_q[g].duty_update_now     <= wd[pptb_pkg::GC_DUN];  // R23
        end
      end

      // Unimplemented bits read as zero
      always_comb begin
        gen_rd[g] = 16'h0000;
        gen_rd[g][pptb_pkg::GC_FST:pptb_pkg::GC_TST] = gstat_q[g];
        gen_rd[g][pptb_pkg::GC_TEN +: 3] = en_q;
        gen_rd[g][pptb_pkg::GC_OPS] = gcfg_q[g].own_period_sel;
        gen_rd[g][pptb_pkg::GC_SDS] = gcfg_q[g].shared_duty_sel;
        gen_rd[g][pptb_pkg::GC_DT +: 2] = gcfg_q[g].deadtime_mode;
        gen_rd[g][pptb_pkg::GC_XR] = gcfg_q[g].ext_counter_restart;
        gen_rd[g][pptb_pkg::GC_DUN] = gcfg_q[g].duty_update_now;
      end
    end
  endgenerate

  // ----------------------------------------------------------------
  // Read mux
  // ----------------------------------------------------------------
  logic [15:0] tbc_rd; // Time base control with pending bit
  logic [15:0] rd_mux; // Selected read word

  always_comb begin
    tbc_rd = tbc_q;
    tbc_rd[pptb_pkg::TBC_SEP] = sep_q;                          // R3
    rd_mux = 16'h0000;
    if (sel_tbc) rd_mux = tbc_rd;
    if (sel_per) rd_mux = {per_q, {CMP_LSB_W{1'b0}}};           // R11
    if (sel_sec) rd_mux = sec_full;                             // R12
    if (sel_mdc) rd_mux = mdc_q;                                // R13
    if (sel_cnt) rd_mux = cnt_q;
    for (int i = 0; i < pptb_pkg::NUM_GEN; i++) begin
      if (sel_gen[i]) rd_mux = gen_rd[i];
    end
  end

  // ----------------------------------------------------------------
  // APB answer: ready rises one cycle into the access phase
  // ----------------------------------------------------------------
  always_ff @(posedge sys_clk_in) begin
    if (sys_rst_in) begin
      pready_q    <= 1'b0;
      prdata_out  <= 32'h0000_0000;
      pslverr_out <= 1'b0;
    end else begin
      pready_q    <= psel_in && penable_in && !pready_q;
      pslverr_out <= psel_in && penable_in && !pready_q && !mapped;
      if (psel_in && penable_in && !pready_q && !pwrite_in) begin
        prdata_out <= {16'h0000, rd_mux};
      end
    end
  end

  assign pready_out = pready_q;

  // ----------------------------------------------------------------
  // Registered outputs
  // ----------------------------------------------------------------
  always_ff @(posedge sys_clk_in) begin
    if (sys_rst_in) begin
      sync_output_pin_out  <= 1'b0;
      special_evt_trig_out <= 1'b0;
      special_evt_irq_out  <= 1'b0;
      gen_irq_out          <= 4'h0;
      primary_counter_out  <= pptb_pkg::RST_WORD;
      master_duty_out      <= pptb_pkg::RST_WORD;
      active_period_out    <= pptb_pkg::RST_WORD;
    end else begin
      sync_output_pin_out  <= roll && sync_out_en;              // R7
      special_evt_trig_out <= sev_trig;                         // R25
      special_evt_irq_out  <= sep_q && special_evt_irq_en;      // R4
      gen_irq_out          <= girq;
      primary_counter_out  <= cnt_q;
      master_duty_out      <= mdc_q;                            // R13
      active_period_out    <= act_full;
    end
  end

  always_ff @(posedge sys_clk_in) begin
    if (sys_rst_in) begin
      gen_cfg_out <= '0;
    end else begin
      for (int i = 0; i < pptb_pkg::NUM_GEN; i++) begin
        gen_cfg_out[i] <= gcfg_q[i];
      end
    end
  end

endmodule // pptb_top

`default_nettype wire

// ### pptb_pkg.sv
package pptb_pkg;

  // ----------------------------------------------------------------
  // Register byte offsets on the APB
  // ----------------------------------------------------------------
  localparam logic [7:0] OFS_TBC   = 8'h00; // Time base control
  localparam logic [7:0] OFS_PER   = 8'h04; // Primary period
  localparam logic [7:0] OFS_SEC   = 8'h08; // Special event compare
  localparam logic [7:0] OFS_MDC   = 8'h0C; // Master duty cycle
  localparam logic [7:0] OFS_GEN0  = 8'h10; // Generator 0 control
  localparam logic [7:0] OFS_CNT   = 8'h20; // Primary counter, read only
  localparam int         GEN_STEP  = 4;     // Bytes between generators
  localparam int         NUM_GEN   = 4;     // Generators in the module

  // ----------------------------------------------------------------
  // Time base control field positions
  // ----------------------------------------------------------------
  localparam int TBC_ON   = 15; // Module enable
  localparam int TBC_IDL  = 13; // Halt in idle
  localparam int TBC_SEP  = 12; // Special event pending
  localparam int TBC_SEE  = 11; // Special event interrupt enable
  localparam int TBC_PUN  = 10; // Immediate period update
  localparam int TBC_SPOL = 9;  // Sync input inverted
  localparam int TBC_SOE  = 8;  // Sync output enable
  localparam int TBC_SEN  = 7;  // External sync enable
  localparam int TBC_SRC  = 4;  // Sync source select, 3 bits
  localparam int TBC_PS   = 0;  // Postscale, 4 bits

  // ----------------------------------------------------------------
  // Generator control field positions
  // ----------------------------------------------------------------
  localparam int GC_FST  = 15; // Fault pending
  localparam int GC_CST  = 14; // Current-limit pending
  localparam int GC_TST  = 13; // Trigger pending
  localparam int GC_FEN  = 12; // Fault interrupt enable
  localparam int GC_CEN  = 11; // Current-limit interrupt enable
  localparam int GC_TEN  = 10; // Trigger interrupt enable
  localparam int GC_OPS  = 9;  // Own period select
  localparam int GC_SDS  = 8;  // Shared duty select
  localparam int GC_DT   = 6;  // Dead-time mode, 2 bits
  localparam int GC_XR   = 1;  // External counter restart
  localparam int GC_DUN  = 0;  // Immediate duty update

  // ----------------------------------------------------------------
  // Widths, codes and reset values
  // ----------------------------------------------------------------
  localparam int         CMP_LSB   = 3;       // Low unimplemented bits
  localparam logic [2:0] SRC_PIN   = 3'h0;    // Dedicated sync pin
  localparam logic [1:0] DT_RSVD   = 2'h3;    // Reserved dead-time code
  localparam logic [15:0] RST_WORD = 16'h0000; // Reset of every register

  // Generator configuration as it leaves the block
  typedef struct packed {
    logic       fault_irq_en;
    logic       curlimit_irq_en;
    logic       trig_irq_en;
    logic       own_period_sel;
    logic       shared_duty_sel;
    logic [1:0] deadtime_mode;
    logic       ext_counter_restart;
    logic       duty_update_now;
  } pptb_gen_cfg_t;

  // Interrupt events of one generator, one-cycle pulses
  typedef struct packed {
    logic fault;
    logic curlimit;
    logic trig;
  } pptb_gen_evt_t;

endpackage

// ### pptb_postscale.sv
`timescale 1ns/10ps
`default_nettype none

module pptb_postscale (
  input  wire logic       sys_clk_in,   // System clock
  input  wire logic       sys_rst_in,   // Synchronous reset, high
  input  wire logic       clear_in,     // Restart the count
  input  wire logic       evt_in,       // Compare match pulse
  input  wire logic [3:0] ratio_in,     // Divide by ratio plus one
  output var  logic       trig_out      // Postscaled trigger pulse
);

  // ----------------------------------------------------------------
  // Event counter
  // ----------------------------------------------------------------
  logic [3:0] count_q;  // Events seen since last trigger
  logic       hit;      // This event completes the ratio

  assign hit = evt_in && (count_q >= ratio_in); // R10

  // Count matches; a smaller ratio written mid-count takes effect
  // at once rather than waiting for a wrap of the old count
  always_ff @(posedge sys_clk_in) begin
    if (sys_rst_in || clear_in) begin
      count_q  <= 4'h0;
      trig_out <= 1'b0;
    end else begin
      trig_out <= hit;
      if (hit) begin
        count_q <= 4'h0;
      end else if (evt_in) begin
        count_q <= count_q + 4'h1;
      end
    end
  end

endmodule // pptb_postscale

`default_nettype wire

// ### pptb_assertions.sv
`timescale 1ns/10ps
`default_nettype none
module pptb_checker (
  input wire logic                          sys_clk_in,
  input wire logic                          sys_rst_in,
  input wire logic                          psel_in,
  input wire logic                          penable_in,
  input wire logic                          pwrite_in,
  input wire logic [7:0]                    paddr_in,
  input wire logic [31:0]                   pwdata_in,
  input wire logic                          pready_out,
  input wire logic                          pslverr_out,
  input wire logic                          special_evt_trig_out,
  input wire pptb_pkg::pptb_gen_evt_t [3:0] gen_evt_in,
  input wire logic [3:0]                    gen_irq_out,
  input wire logic [15:0]                   primary_counter_out,
  input wire logic [15:0]                   master_duty_out,
  input wire logic [15:0]                   active_period_out
);
  // ----------------------------------------
  // Written state mirror
  // ----------------------------------------
  logic        on_q;   // Written enable
  logic [15:0] mdc_q;  // Master duty as last written
  logic [15:0] sec_q;  // Compare value, low bits dropped
  wire wr  = psel_in && penable_in && pready_out && pwrite_in; // Completed write
  wire evt = |gen_evt_in[0];                                    // Any event on generator 0
  // Mirror completed writes
  always_ff @(posedge sys_clk_in) begin
    if (sys_rst_in) begin
      on_q  <= 1'b0;
      mdc_q <= 16'h0000;
      sec_q <= 16'h0000;
    end else if (wr) begin
      if (paddr_in == pptb_pkg::OFS_TBC) on_q <= pwdata_in[15];
      if (paddr_in == pptb_pkg::OFS_MDC) mdc_q <= pwdata_in[15:0];
      if (paddr_in == pptb_pkg::OFS_SEC) sec_q <= {pwdata_in[15:3], 3'h0};
    end
  end
  // ----------------------------------------
  // Properties
  // ----------------------------------------
  default clocking @(posedge sys_clk_in); endclocking
  default disable iff (sys_rst_in);
  sequence s_mdc_wr;
    wr && paddr_in == pptb_pkg::OFS_MDC;
  endsequence
  AST_READY_WAIT: assert property (psel_in && penable_in && !pready_out |=> pready_out)
    else $error("no ready");
  AST_UNMAPPED_ERR: assert property (pready_out && (paddr_in > pptb_pkg::OFS_CNT || paddr_in[1:0] != 2'h0)
    |-> pslverr_out) else $error("no slave error");
  AST_OFF_ZERO: assert property (!on_q [*3] |-> primary_counter_out == 16'h0000)
    else $error("counter runs off");
  AST_CNT_STEP: assert property (primary_counter_out != 16'h0000 |->
    primary_counter_out == $past(primary_counter_out) + 16'h0001 || $stable(primary_counter_out))
    else $error("bad counter step");
  AST_PER_LOW: assert property (active_period_out[2:0] == 3'h0)
    else $error("period low bits not zero");
  AST_MDC_LOAD: assert property (s_mdc_wr |-> ##[1:2] master_duty_out == mdc_q)
    else $error("duty not loaded");
  AST_TRIG_CMP: assert property (special_evt_trig_out |-> $past(primary_counter_out) == sec_q)
    else $error("trigger without match");
  AST_GEN_CAUSE: assert property ($rose(gen_irq_out[0]) |-> $past(evt) || $past(evt, 2))
    else $error("request without event");
endmodule // pptb_checker
bind pptb_top pptb_checker i_pptb_checker (.sys_clk_in, .sys_rst_in, .psel_in, .penable_in, .pwrite_in,
  .paddr_in, .pwdata_in, .pready_out, .pslverr_out, .special_evt_trig_out, .gen_evt_in, .gen_irq_out,
  .primary_counter_out, .master_duty_out, .active_period_out);
`default_nettype wire

// ### tb.sv
`timescale 1ns/10ps
`default_nettype none
`define CHK(nm, ex, gt) begin check_count++; if ((gt) !== (ex)) begin n_errors++; \
  $display("CHECK FAILED %s exp %h got %h", nm, ex, gt); end end
module tb;
  // ----------------------------------------
  // Stimulus and observed signals
  // ----------------------------------------
  logic sys_clk_in = 0, sys_rst_in = 1, psel_in = 0, penable_in = 0, pwrite_in = 0;
  logic cpu_idle_in = 0, sync_input_pin_in = 0;
  logic [7:0] paddr_in = 8'h00;
  logic [31:0] pwdata_in = 32'h0, prdata_out, rd;
  logic pready_out, pslverr_out, sync_output_pin_out, special_evt_trig_out, special_evt_irq_out, err;
  logic [3:0] gen_irq_out;
  logic [15:0] primary_counter_out, master_duty_out, active_period_out, hold;
  pptb_pkg::pptb_gen_evt_t [3:0] gen_evt_in = '0;
  pptb_pkg::pptb_gen_cfg_t [3:0] gen_cfg_out;
  int n_errors = 0, check_count = 0, cyc = 0, k, n;
  always #50 sys_clk_in = ~sys_clk_in;
  pptb_top i_pptb_top (.sys_clk_in, .sys_rst_in, .psel_in, .penable_in, .pwrite_in, .paddr_in, .pwdata_in,
    .prdata_out, .pready_out, .pslverr_out, .cpu_idle_in, .sync_input_pin_in, .gen_evt_in,
    .sync_output_pin_out, .special_evt_trig_out, .special_evt_irq_out, .gen_irq_out,
    .primary_counter_out, .master_duty_out, .active_period_out, .gen_cfg_out);
  // ----------------------------------------
  // Bus tasks and closing report
  // ----------------------------------------
  // Idle edge first avoids double assignment
  task automatic xf(input logic w, input logic [7:0] a, input logic [15:0] d);
    @(posedge sys_clk_in);
    psel_in <= 1; pwrite_in <= w; paddr_in <= a; pwdata_in <= {16'h0000, d};
    @(posedge sys_clk_in);
    penable_in <= 1;
    n = 0;
    do begin @(posedge sys_clk_in); n++; end while (pready_out !== 1'b1 && n < 16);
    rd = prdata_out; err = pslverr_out; psel_in <= 0; penable_in <= 0;
  endtask
  task automatic rdchk(input string nm, input logic [7:0] a, input logic [15:0] ex);
    xf(0, a, 16'h0000);
    `CHK(nm, ex, rd[15:0])
  endtask
  task automatic summarize;
    if (n_errors == 0 && check_count > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask
  // Hang guard
  always @(posedge sys_clk_in) begin
    cyc++;
    if (cyc == 3000) begin n_errors++; summarize(); end
  end
  // ----------------------------------------
  // Main sequence
  // ----------------------------------------
  initial begin
    repeat (8) @(posedge sys_clk_in);
    sys_rst_in <= 0;
    for (k = 0; k < 5; k++) rdchk("reset", 8'(4 * k), 16'h0000);
    xf(1, pptb_pkg::OFS_PER, 16'hFFFF); rdchk("period", pptb_pkg::OFS_PER, 16'hFFF8);
    xf(1, pptb_pkg::OFS_SEC, 16'hFFFF); rdchk("compare", pptb_pkg::OFS_SEC, 16'hFFF8);
    xf(1, pptb_pkg::OFS_MDC, 16'hFFEF); rdchk("mduty", pptb_pkg::OFS_MDC, 16'hFFEF);
    xf(0, 8'h24, 16'h0000); `CHK("slverr", 1'b1, err)
    for (k = 0; k < 3; k++) begin xf(1, pptb_pkg::OFS_GEN0, 16'(k << 6)); rdchk("dt", 8'h10, 16'(k << 6)); end
    // Reserved dead-time code keeps old mode
    xf(1, pptb_pkg::OFS_GEN0, 16'hFFFF); rdchk("genctl", pptb_pkg::OFS_GEN0, 16'h1F83);
    @(posedge sys_clk_in) gen_evt_in[0].fault <= 1;
    @(posedge sys_clk_in) gen_evt_in[0].fault <= 0;
    rdchk("fault", pptb_pkg::OFS_GEN0, 16'h9F83);
    `CHK("genirq", 1'b1, gen_irq_out[0])
    xf(1, pptb_pkg::OFS_GEN0, 16'h0F83); rdchk("fltclr", pptb_pkg::OFS_GEN0, 16'h0F83);
    // 9 states, 1:2 postscale: trigger per 18 cycles
    xf(1, pptb_pkg::OFS_PER, 16'h0008); xf(1, pptb_pkg::OFS_SEC, 16'h0000);
    xf(1, pptb_pkg::OFS_TBC, 16'hA901);
    n = 0;
    while (special_evt_trig_out !== 1'b1 && n < 100) begin @(posedge sys_clk_in); n++; end
    k = 0;
    repeat (180) begin @(posedge sys_clk_in); if (special_evt_trig_out === 1'b1) k++; end
    `CHK("trigs", 10, k)
    `CHK("seirq", 1'b1, special_evt_irq_out)
    rdchk("pending", pptb_pkg::OFS_TBC, 16'hB901);
    cpu_idle_in <= 1;
    repeat (3) @(posedge sys_clk_in);
    hold = primary_counter_out;
    repeat (5) @(posedge sys_clk_in);
    `CHK("halt", hold, primary_counter_out)
    cpu_idle_in <= 0;
    xf(1, pptb_pkg::OFS_TBC, 16'h0000);
    repeat (3) @(posedge sys_clk_in);
    `CHK("off", 16'h0000, primary_counter_out)
    summarize();
  end
endmodule // tb
`default_nettype wire
